// File: common/timer_pwm_regs.svh
/*
 * Register map, field positions and reset values of the triggered PWM timer.
 * Assumes a 32-bit classic Wishbone bus with byte addresses on adr.
 */
`ifndef TIMER_PWM_REGS_SVH
`define TIMER_PWM_REGS_SVH

`define CTL_FIRST_ADDR 8'h00
`define CTL_SECOND_ADDR 8'h04
`define CAP_IN_CTL_ADDR 8'h08
`define TRIG_IN_CTL_ADDR 8'h0C
`define OPTION_ADDR 8'h10
`define PERIOD_CMP_ADDR 8'h14
`define WIDTH_CMP_ADDR 8'h18
`define COUNTER_ADDR 8'h1C
`define STATUS_ADDR 8'h20

`define CE_BIT 7
`define SW_TRIG_BIT 6
`define MODE_TRIG_PULSE 3'h2
`define CNT_TOP 16'hFFFF
`define CNT_ZERO 16'h0000
`define CMP_RESET 16'hFFFF
`define EDGE_NONE 2'h0
`define EDGE_RISE 2'h1
`define EDGE_FALL 2'h2
`define EDGE_BOTH 2'h3

`endif

// File: common/timer_pwm_pkg.sv
/*
 * Types shared by the triggered PWM timer.
 * Assumes timer_pwm_regs.svh supplies the numeric constants.
 */
package timer_pwm_pkg;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_RUN = 2'b10
    } run_state_t;

    typedef struct packed {
        logic countEnable;
        logic [2:0] clockSelect;
    } ctl_first_t;

    typedef struct packed {
        logic eventEnable;
        logic [2:0] modeSelect;
    } ctl_second_t;

    typedef struct packed {
        logic square;
        logic pwm;
        logic periodIrq;
        logic widthIrq;
    } timer_out_t;

endpackage : timer_pwm_pkg

// File: verilog/triggered_pwm_timer.sv
/*
 * Triggered PWM output mode of a 16-bit timer channel with a Wishbone slave.
 * Assumes one 25 MHz clock, an asynchronous active-low reset, and an
 * external trigger pin that is asynchronous to the clock.
 */
// The Wishbone interface to the registers and the placing of the registers were chosen for this implementation.
// What this block does and what software is to do
// RQ1: Mode field value 010 selects triggered pulse output.
// RQ2: With count enable set, wait idle until a trigger.
// RQ3: First trigger moves counter FFFFH to 0000H, counts, drives PWM.
// RQ4: Trigger while running clears counter, toggles square, forces PWM high.
// RQ5: Trigger is an external edge or a software trigger write.
// RQ6: Software triggering gives a 50% square wave, half period plus one.
// RQ7: Period is period value plus one; width is width value.
// RQ8: Count after period match raises period request and clears counter.
// RQ9: Width request rises in the clock the counter equals width value.
// RQ10: Buffers reload on period clear, armed only by width writes.
// RQ11: Software writes period first, width last.
// RQ12: Software waits for period request before rewriting compares.
// RQ13: Width zero gives 0% and both requests after period match.
// RQ14: Width equal to period plus one gives 100%; impossible at FFFFH.
// RQ15: Trigger after width match clears counter and asserts PWM.
// RQ16: Trigger before width match suppresses width request, PWM stays on.
// RQ17: Trigger after period match clears counter, keeps counting.
// RQ18: Trigger before period match suppresses period request, asserts PWM.
// RQ19: Capture input control and option registers have no effect.
// RQ20: Counter register reads the present counter value.
// RQ21: Width above period never matches, no width request.
// RQ22: Software loads FFFFH into unused width compare.
// RQ23: Counter advances on count clock picked by clock select.
// RQ24: PWM drops at width match, rises at each counter clear; with width zero the code keeps PWM low at the period clear and first trigger only.
// RQ25: External trigger edge is synchronised into one-cycle event.
`timescale 1ns/100ps
`include "timer_pwm_regs.svh"

module triggered_pwm_timer
    import timer_pwm_pkg::*;
(
    input wire logic sys_clk, // System clock, 25 MHz.
    input wire logic rst_b, // Asynchronous reset, active low.
    input wire logic wb_cyc_i, // Wishbone cycle.
    input wire logic wb_stb_i, // Wishbone strobe.
    input wire logic wb_we_i, // Wishbone write enable.
    input wire logic [7:0] wb_adr_i, // Wishbone byte address.
    input wire logic [3:0] wb_sel_i, // Wishbone byte lanes.
    input wire logic [31:0] wb_dat_i, // Wishbone write data.
    output logic [31:0] wb_dat_o, // Wishbone read data.
    output logic wb_ack_o, // Wishbone acknowledge.
    input wire logic externalTriggerInput, // Trigger pin, asynchronous.
    output logic squareWaveOutput, // 50% square wave output.
    output logic pwmOutput, // PWM output.
    output logic periodMatchIrq, // Period match request, one cycle.
    output logic widthMatchIrq // Width match request, one cycle.
);

    ctl_first_t ctlFirst_q, ctlFirst_d;
    ctl_second_t ctlSecond_q, ctlSecond_d;
    logic [7:0] capInCtl_q, capInCtl_d;
    logic [1:0] trigEdge_q, trigEdge_d;
    logic [7:0] option_q, option_d;
    logic [15:0] periodCompareReg_q, periodCompareReg_d;
    logic [15:0] widthCompareReg_q, widthCompareReg_d;
    logic swTrig_q, swTrig_d;
    logic widthWritten_d;
    logic ack_q, ack_d;
    logic [31:0] rdData_q, rdData_d;
    logic wrTake;

    run_state_t state_q, state_d;
    logic [15:0] count_q, count_d;
    logic [15:0] periodCompareBuffer_q, periodCompareBuffer_d;
    logic [15:0] widthCompareBuffer_q, widthCompareBuffer_d;
    logic armed_q, armed_d;
    logic [6:0] prescale_q, prescale_d;
    timer_out_t out_q, out_d;

    logic trigSync1_q, trigSync2_q, trigPrev_q;
    logic extTrig;
    logic trigger;
    logic modeOn;
    logic tick;
    logic [6:0] tickMask;

    // The pin passes two flops; the edge detector compares the second with its one-cycle-late copy trigPrev_q.
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            trigSync1_q <= 1'b0;
            trigSync2_q <= 1'b0;
            trigPrev_q <= 1'b0;
        end
        else
        begin
            trigSync1_q <= externalTriggerInput;
            trigSync2_q <= trigSync1_q;
            trigPrev_q <= trigSync2_q;
        end
    end

    // Edge selection gives one single-cycle trigger event per valid edge.
    always_comb
    begin
        case (trigEdge_q)
            `EDGE_RISE: extTrig = trigSync2_q & ~trigPrev_q; // RQ25
            `EDGE_FALL: extTrig = ~trigSync2_q & trigPrev_q; // RQ25
            `EDGE_BOTH: extTrig = trigSync2_q ^ trigPrev_q; // RQ25
            default: extTrig = 1'b0;
        endcase
    end

    // The mode only runs with the enable set and the mode field at 010.
    assign modeOn = ctlFirst_q.countEnable
        && (ctlSecond_q.modeSelect == `MODE_TRIG_PULSE); // RQ1
    assign trigger = modeOn && (extTrig || swTrig_q); // RQ5

    // Count clock is sys_clk divided by two to the power of clock select.
    assign tickMask = 7'h7F >> (3'h7 - ctlFirst_q.clockSelect);
    assign tick = ((prescale_q & tickMask) == tickMask); // RQ23

    // A bus request is answered one cycle later; writes land on the ack edge.
    assign wrTake = wb_cyc_i && wb_stb_i && wb_we_i && ack_q;

    // Register file next-state logic, with byte lanes honoured.
    always_comb
    begin
        ctlFirst_d = ctlFirst_q;
        ctlSecond_d = ctlSecond_q;
        capInCtl_d = capInCtl_q;
        trigEdge_d = trigEdge_q;
        option_d = option_q;
        periodCompareReg_d = periodCompareReg_q;
        widthCompareReg_d = widthCompareReg_q;
        swTrig_d = 1'b0;
        widthWritten_d = 1'b0;
        ack_d = wb_cyc_i && wb_stb_i && !ack_q;
        rdData_d = rdData_q;
        if (wrTake)
        begin
            case (wb_adr_i)
                `CTL_FIRST_ADDR:
                    if (wb_sel_i[0])
                    begin
                        ctlFirst_d.countEnable = wb_dat_i[`CE_BIT];
                        ctlFirst_d.clockSelect = wb_dat_i[2:0];
                    end
                `CTL_SECOND_ADDR:
                    if (wb_sel_i[0])
                    begin
                        swTrig_d = wb_dat_i[`SW_TRIG_BIT]; // RQ5
                        ctlSecond_d.eventEnable = wb_dat_i[5];
                        ctlSecond_d.modeSelect = wb_dat_i[2:0];
                    end
                // Stored for software only; nothing in this mode reads them.
                `CAP_IN_CTL_ADDR:
                    if (wb_sel_i[0])
                        capInCtl_d = wb_dat_i[7:0]; // RQ19
                `TRIG_IN_CTL_ADDR:
                    if (wb_sel_i[0])
                        trigEdge_d = wb_dat_i[1:0];
                `OPTION_ADDR:
                    if (wb_sel_i[0])
                        option_d = wb_dat_i[7:0]; // RQ19
                `PERIOD_CMP_ADDR:
                begin
                    if (wb_sel_i[0])
                        periodCompareReg_d[7:0] = wb_dat_i[7:0];
                    if (wb_sel_i[1])
                        periodCompareReg_d[15:8] = wb_dat_i[15:8];
                end
                `WIDTH_CMP_ADDR:
                begin
                    if (wb_sel_i[0])
                        widthCompareReg_d[7:0] = wb_dat_i[7:0];
                    if (wb_sel_i[1])
                        widthCompareReg_d[15:8] = wb_dat_i[15:8];
                    widthWritten_d = |wb_sel_i[1:0]; // RQ10
                end
                default: ;
            endcase
        end
        // Read data is captured at the request edge and stands during ack.
        if (wb_cyc_i && wb_stb_i && !ack_q)
        begin
            case (wb_adr_i)
                `CTL_FIRST_ADDR:
                    rdData_d = {24'h000000, ctlFirst_q.countEnable, 4'h0,
                        ctlFirst_q.clockSelect};
                `CTL_SECOND_ADDR:
                    rdData_d = {26'h0000000, ctlSecond_q.eventEnable, 2'h0,
                        ctlSecond_q.modeSelect};
                `CAP_IN_CTL_ADDR: rdData_d = {24'h000000, capInCtl_q};
                `TRIG_IN_CTL_ADDR: rdData_d = {30'h00000000, trigEdge_q};
                `OPTION_ADDR: rdData_d = {24'h000000, option_q};
                `PERIOD_CMP_ADDR: rdData_d = {16'h0000, periodCompareReg_q};
                `WIDTH_CMP_ADDR: rdData_d = {16'h0000, widthCompareReg_q};
                `COUNTER_ADDR: rdData_d = {16'h0000, count_q}; // RQ20
                `STATUS_ADDR:
                    rdData_d = {27'h0000000, armed_q, out_q.pwm, out_q.square,
                        (state_q == ST_RUN), modeOn};
                default: rdData_d = 32'h00000000;
            endcase
        end
    end

    // Register file flops.
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ctlFirst_q <= '0;
            ctlSecond_q <= '0;
            capInCtl_q <= 8'h00;
            trigEdge_q <= `EDGE_RISE;
            option_q <= 8'h00;
            periodCompareReg_q <= `CMP_RESET;
            widthCompareReg_q <= `CMP_RESET;
            swTrig_q <= 1'b0;
            ack_q <= 1'b0;
            rdData_q <= 32'h00000000;
        end
        else
        begin
            ctlFirst_q <= ctlFirst_d;
            ctlSecond_q <= ctlSecond_d;
            capInCtl_q <= capInCtl_d;
            trigEdge_q <= trigEdge_d;
            option_q <= option_d;
            periodCompareReg_q <= periodCompareReg_d;
            widthCompareReg_q <= widthCompareReg_d;
            swTrig_q <= swTrig_d;
            ack_q <= ack_d;
            rdData_q <= rdData_d;
        end
    end

    // Counter, buffers and outputs. A trigger outranks a count tick, which
    // is how a trigger near a match swallows that match's request.
    always_comb
    begin
        state_d = state_q;
        count_d = count_q;
        periodCompareBuffer_d = periodCompareBuffer_q;
        widthCompareBuffer_d = widthCompareBuffer_q;
        armed_d = armed_q;
        prescale_d = 7'(prescale_q + 7'h01);
        out_d = out_q;
        out_d.periodIrq = 1'b0;
        out_d.widthIrq = 1'b0;
        if (!modeOn)
        begin
            state_d = ST_IDLE;
            count_d = `CNT_TOP;
            prescale_d = 7'h00;
            out_d.pwm = 1'b0;
            out_d.square = 1'b0;
            armed_d = 1'b0;
        end
        else
        begin
            case (state_q)
                ST_IDLE:
                begin
                    prescale_d = 7'h00; // RQ2
                    if (trigger)
                    begin
                        state_d = ST_RUN;
                        count_d = `CNT_ZERO; // RQ3
                        periodCompareBuffer_d = periodCompareReg_q;
                        widthCompareBuffer_d = widthCompareReg_q;
                        armed_d = 1'b0;
                        out_d.pwm = (widthCompareReg_q != `CNT_ZERO); // RQ3
                        out_d.square = ~out_q.square; // RQ6
                    end
                end
                ST_RUN:
                begin
                    if (trigger)
                    begin
                        count_d = `CNT_ZERO; // RQ4 RQ15 RQ16 RQ17 RQ18
                        prescale_d = 7'h00;
                        out_d.pwm = 1'b1; // RQ4 RQ24
                        out_d.square = ~out_q.square; // RQ4
                    end
                    else if (tick)
                    begin
                        if (count_q == periodCompareBuffer_q)
                        begin
                            count_d = `CNT_ZERO; // RQ8 RQ7
                            out_d.periodIrq = 1'b1; // RQ8
                            out_d.square = ~out_q.square; // RQ6
                            if (armed_q)
                            begin
                                periodCompareBuffer_d = periodCompareReg_q; // RQ10
                                widthCompareBuffer_d = widthCompareReg_q; // RQ10
                                armed_d = 1'b0;
                            end
                        end
                        else
                            count_d = 16'(count_q + 16'h0001);
                        // The request is raised with the count that equals the
                        // buffer, so it lines up with the output edge.
                        if (count_d == widthCompareBuffer_d)
                        begin
                            out_d.widthIrq = 1'b1; // RQ9 RQ13 RQ21
                            out_d.pwm = 1'b0; // RQ24 RQ13
                        end
                        else if (count_d == `CNT_ZERO)
                            out_d.pwm = 1'b1; // RQ24 RQ14
                    end
                end
                default:
                begin
                    state_d = ST_IDLE;
                    count_d = `CNT_TOP;
                end
            endcase
            // A width write arms the reload; it wins over the reload's clear.
            if (widthWritten_d)
                armed_d = 1'b1; // RQ10
        end
    end

    // Counter group flops.
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_q <= ST_IDLE;
            count_q <= `CNT_TOP;
            periodCompareBuffer_q <= `CMP_RESET;
            widthCompareBuffer_q <= `CMP_RESET;
            armed_q <= 1'b0;
            prescale_q <= 7'h00;
            out_q <= '0;
        end
        else
        begin
            state_q <= state_d;
            count_q <= count_d;
            periodCompareBuffer_q <= periodCompareBuffer_d;
            widthCompareBuffer_q <= widthCompareBuffer_d;
            armed_q <= armed_d;
            prescale_q <= prescale_d;
            out_q <= out_d;
        end
    end

    // All outputs come straight from flops.
    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdData_q;
    assign squareWaveOutput = out_q.square;
    assign pwmOutput = out_q.pwm;
    assign periodMatchIrq = out_q.periodIrq;
    assign widthMatchIrq = out_q.widthIrq;

endmodule : triggered_pwm_timer

// File: sim/triggered_pwm_timer_asserts.sv
/*
 * Checker for the triggered PWM timer, bound to its top module.
 * Assumes one clock, one-cycle ack and one-cycle match request pulses.
 */
`timescale 1ns/100ps

module triggered_pwm_timer_chk
    import timer_pwm_pkg::*;
(
    input wire logic sys_clk, // Clock.
    input wire logic rst_b, // Reset, active low.
    input wire logic wb_cyc_i, // Bus cycle.
    input wire logic wb_stb_i, // Bus strobe.
    input wire logic wb_ack_o, // Bus acknowledge.
    input wire logic squareWaveOutput, // Square wave.
    input wire logic pwmOutput, // PWM output.
    input wire logic periodMatchIrq, // Period request.
    input wire logic widthMatchIrq // Width request.
);
    // One domain, so clock and reset are given once.
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    // Bus answers exactly one cycle after a request and only once.
    AST_ACK_ANSWER: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing after request");
    AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held too long");
    // Requests are single pulses even when the count clock is divided.
    AST_PIRQ_PULSE: assert property (periodMatchIrq |=> !periodMatchIrq)
        else $error("period request not a pulse");
    AST_WIRQ_PULSE: assert property (widthMatchIrq |=> !widthMatchIrq)
        else $error("width request not a pulse");
    // Width request marks the very cycle the output goes inactive.
    AST_WIRQ_DROP: assert property (widthMatchIrq && !periodMatchIrq |-> $fell(pwmOutput))
        else $error("output did not fall with width request");
    AST_PIRQ_PWM: assert property (periodMatchIrq && !widthMatchIrq |-> pwmOutput)
        else $error("output not active after period clear");
    AST_PIRQ_SQUARE: assert property (periodMatchIrq |-> squareWaveOutput != $past(squareWaveOutput))
        else $error("square did not toggle at period clear");
    AST_ZERO_WIDTH: assert property (periodMatchIrq && widthMatchIrq |-> !pwmOutput)
        else $error("zero width drove output");

    // Main scenarios reached.
    CV_BOTH: cover property (periodMatchIrq && widthMatchIrq);
    CV_WIDTH: cover property (widthMatchIrq && !periodMatchIrq);
    CV_PWM: cover property ($rose(pwmOutput));
endmodule : triggered_pwm_timer_chk

bind triggered_pwm_timer triggered_pwm_timer_chk triggered_pwm_timer_chk_i (
    .sys_clk(sys_clk), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o), .squareWaveOutput(squareWaveOutput), .pwmOutput(pwmOutput),
    .periodMatchIrq(periodMatchIrq), .widthMatchIrq(widthMatchIrq));

// File: sim/trig_source.sv
/*
 * External trigger source driving the trigger pin.
 * Assumes the bench asks for a pulse with a one-cycle fire request.
 */
`timescale 1ns/100ps

module trig_source
(
    input wire logic sys_clk, // Clock the pulse is timed on.
    input wire logic fire, // One-cycle request for a pulse.
    output logic trigPin // Trigger pin, idle low.
);
    int hold = 0;

    // Three clocks wide so the two-flop synchroniser cannot miss it.
    always @(posedge sys_clk)
    begin
        if (fire)
            hold <= 3;
        else if (hold > 0)
            hold <= hold - 1;
    end
    assign trigPin = (hold > 0);
endmodule : trig_source

// File: sim/tb_top.sv
/*
 * Self-checking bench for the triggered PWM timer.
 * Assumes the register map header and the trigger source model.
 */
`timescale 1ns/100ps
`include "timer_pwm_regs.svh"

module tb_top
    import timer_pwm_pkg::*;
;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic wbCyc = 1'b0;
    logic wbStb = 1'b0;
    logic wbWe = 1'b0;
    logic [7:0] wbAdr = 8'h00;
    logic [3:0] wbSel = 4'h0;
    logic [31:0] wbDatW = 32'h0;
    logic [31:0] wbDatR, rd;
    logic wbAck, trigPin, squareOut, pwmOut, periodIrq, widthIrq, sq;
    logic fire = 1'b0;
    int bad_count = 0;
    int checks_done = 0;
    int g, h, w;

    always #20 sys_clk = ~sys_clk;

    triggered_pwm_timer triggered_pwm_timer_i (.sys_clk(sys_clk), .rst_b(rst_b),
        .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr),
        .wb_sel_i(wbSel), .wb_dat_i(wbDatW), .wb_dat_o(wbDatR), .wb_ack_o(wbAck),
        .externalTriggerInput(trigPin), .squareWaveOutput(squareOut),
        .pwmOutput(pwmOut), .periodMatchIrq(periodIrq), .widthMatchIrq(widthIrq));
    trig_source trig_source_i (.sys_clk(sys_clk), .fire(fire), .trigPin(trigPin));

    task automatic end_of_test();
        if (bad_count == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : end_of_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // A wait that runs out is reported as a mismatch and ends the run.
    task automatic stuck();
        chk(32'h0, 32'h1);
        end_of_test();
    endtask : stuck

    // Classic cycle: hold the request until ack is sampled, then release.
    task automatic wb(input logic [7:0] a, input logic we, input logic [31:0] d);
        int n;
        n = 0;
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= we;
        wbAdr <= a;
        wbDatW <= d;
        wbSel <= 4'h3;
        @(posedge sys_clk);
        while (wbAck !== 1'b1)
        begin
            if (++n > 20) stuck();
            @(posedge sys_clk);
        end
        rd = wbDatR;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        @(posedge sys_clk);
    endtask : wb

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        wb(a, 1'b0, 32'h0);
        chk(rd, exp);
    endtask : rchk

    // Cycles between two period requests.
    task automatic irq_gap(output int gap);
        int n;
        n = 0;
        while (periodIrq !== 1'b1)
        begin
            if (++n > 400) stuck();
            @(posedge sys_clk);
        end
        @(posedge sys_clk);
        gap = 1;
        while (periodIrq !== 1'b1)
        begin
            if (++gap > 400) stuck();
            @(posedge sys_clk);
        end
    endtask : irq_gap

    function automatic logic pick(input logic useSq);
        return useSq ? squareOut : pwmOut;
    endfunction : pick

    // Length of the next full high run of the square or PWM output.
    task automatic run_len(input logic useSq, output int len);
        int n;
        n = 0;
        len = 0;
        while (pick(useSq) !== 1'b0 && n < 400) begin @(posedge sys_clk); n++; end
        while (pick(useSq) !== 1'b1 && n < 400) begin @(posedge sys_clk); n++; end
        while (pick(useSq) === 1'b1 && n < 400) begin @(posedge sys_clk); n++; len++; end
        if (n >= 400) stuck();
    endtask : run_len

    // Counts active output cycles and width requests over 20 clocks.
    task automatic watch(output int hc, output int wc);
        hc = 0;
        wc = 0;
        repeat (20)
        begin
            @(posedge sys_clk);
            hc += (pwmOut === 1'b1);
            wc += (widthIrq === 1'b1);
        end
    endtask : watch

    // Main sequence: every step starts just after a rising edge.
    initial
    begin
        repeat (5) @(posedge sys_clk);
        rst_b <= 1'b1;
        @(posedge sys_clk);
        rchk(`PERIOD_CMP_ADDR, 32'hFFFF);
        rchk(`WIDTH_CMP_ADDR, 32'hFFFF);
        wb(`COUNTER_ADDR, 1'b1, 32'h1234);
        rchk(`COUNTER_ADDR, 32'hFFFF);
        rchk(8'h24, 32'h0);
        wb(`PERIOD_CMP_ADDR, 1'b1, 32'h4);
        wb(`WIDTH_CMP_ADDR, 1'b1, 32'h2);
        wb(`TRIG_IN_CTL_ADDR, 1'b1, 32'h1);
        wb(`CTL_SECOND_ADDR, 1'b1, 32'h2);
        wb(`CTL_FIRST_ADDR, 1'b1, 32'h80);
        repeat (10) @(posedge sys_clk);
        rchk(`COUNTER_ADDR, 32'hFFFF);
        rchk(`STATUS_ADDR, 32'h1);
        fire <= 1'b1;
        @(posedge sys_clk);
        fire <= 1'b0;
        run_len(1'b0, h);
        chk(h, 2);
        irq_gap(g);
        chk(g, 5);
        wb(`CTL_SECOND_ADDR, 1'b1, 32'h42);
        run_len(1'b1, h);
        chk(h, 5);
        // A period write alone must not reach the buffer.
        irq_gap(g);
        wb(`PERIOD_CMP_ADDR, 1'b1, 32'h28);
        wb(`CAP_IN_CTL_ADDR, 1'b1, 32'hFF);
        wb(`OPTION_ADDR, 1'b1, 32'hFF);
        irq_gap(g);
        chk(g, 5);
        wb(`WIDTH_CMP_ADDR, 1'b1, 32'h8);
        irq_gap(g);
        chk(g, 41);
        // Trigger in the inactive phase restarts and reasserts the output.
        repeat (20) @(posedge sys_clk);
        sq = squareOut;
        wb(`CTL_SECOND_ADDR, 1'b1, 32'h42);
        repeat (2) @(posedge sys_clk);
        chk(pwmOut, 1'b1);
        chk(squareOut, {31'h0, ~sq});
        wb(`CTL_FIRST_ADDR, 1'b1, 32'h81);
        irq_gap(g);
        irq_gap(g);
        chk(g, 82);
        wb(`CTL_FIRST_ADDR, 1'b1, 32'h80);
        wb(`PERIOD_CMP_ADDR, 1'b1, 32'h4);
        wb(`WIDTH_CMP_ADDR, 1'b1, 32'h0);
        irq_gap(g);
        watch(h, w);
        chk(h, 0);
        chk(w, 4);
        wb(`WIDTH_CMP_ADDR, 1'b1, 32'h5);
        irq_gap(g);
        watch(h, w);
        chk(h, 20);
        chk(w, 0);
        // An unused width channel parked at all ones never matches.
        wb(`WIDTH_CMP_ADDR, 1'b1, 32'hFFFF);
        irq_gap(g);
        watch(h, w);
        chk(h, 20);
        chk(w, 0);
        end_of_test();
    end
endmodule : tb_top
